// ---- common/dftm_pkg.sv ----
// Package for the drive fault-trip manager: register map, fault indices, timing counts.
// Assumes a 10 MHz system clock and 32-bit AXI4-Lite register access.
`default_nettype none
package dftm_pkg;
    // -------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned BRAKE_LOW_MS = 10000;
    localparam int unsigned KEYPAD_LOSS_MS = 2000;
    localparam int unsigned BRAKE_LOW_CYC = BRAKE_LOW_MS * (CLK_HZ / 1000);
    localparam int unsigned KEYPAD_LOSS_CYC = KEYPAD_LOSS_MS * (CLK_HZ / 1000);

    // -------------------------------------------------------------------
    // Fault indices (bit positions in status, mask and trip vectors)
    // -------------------------------------------------------------------
    localparam int NUM_FAULTS = 17;
    localparam int F_NTC = 0;
    localparam int F_FAN = 1;
    localparam int F_THERM = 2;
    localparam int F_PWRITE = 3;
    localparam int F_OVSPD = 4;
    localparam int F_DEVSPD = 5;
    localparam int F_ENC = 6;
    localparam int F_PREPID = 7;
    localparam int F_BRAKE = 8;
    localparam int F_KPAD = 9;
    localparam int F_CMD = 10;
    localparam int F_OPT1 = 11;
    localparam int F_OPT2 = 12;
    localparam int F_OPT3 = 13;
    localparam int F_IOB = 14;
    localparam int F_FATAL0 = 15;
    localparam int F_FATAL1 = 16;

    // Clearing disciplines: 1 = level category
    localparam logic [NUM_FAULTS-1:0] LEVEL_MASK = 17'h00600;
    // 1 = fatal category
    localparam logic [NUM_FAULTS-1:0] FATAL_MASK = 17'h18000;

    // -------------------------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] A_CONFIG = 8'h00;
    localparam logic [7:0] A_SPEED = 8'h04;
    localparam logic [7:0] A_CURRENT = 8'h08;
    localparam logic [7:0] A_TRIP = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    localparam logic [7:0] A_CODE = 8'h18;
    localparam logic [7:0] A_HIST = 8'h1C;

    // CONFIG field positions
    localparam int C_FANACT = 0;
    localparam int C_THERM = 1;
    localparam int C_DEVCHK = 2;
    localparam int C_ENCCHK = 3;
    localparam int C_KPLOSS = 4;
    localparam int C_CMDLOSS = 5;
    localparam int C_SMALL = 6;
    localparam int C_CTRL_LO = 8; // Control method, 2 bits
    localparam logic [1:0] CTRL_VECTOR = 2'h3;

    localparam logic [31:0] CONFIG_RST = 32'h00000001;
    localparam logic [15:0] OVSPD_RST = 16'hFFFF;
    localparam logic [2:0] RESP_OKAY = 3'h0;

    // Detector inputs grouped together
    typedef struct packed {
        logic ntcFault;
        logic fanError;
        logic extThermHigh;
        logic paramWriteFail;
        logic encoderFault;
        logic prePidActive;
        logic prePidLow;
        logic brakeOutAssigned;
        logic keypadRun;
        logic keypadAlive;
        logic cmdFail;
        logic running;
        logic [2:0] optPresent;
        logic ioBoardFault;
        logic [1:0] fatalDiag;
    } dftm_det_t;
endpackage
`default_nettype wire

// ---- logic/dftm_top.sv ----
// Drive fault-trip manager: detector inputs in, trip status and power-stage block out.
// Assumes detectors come from other clock domains and are synchronised here;
// speed and current words come over AXI4-Lite from the control processor.
`timescale 1ns/1ns
`default_nettype none
module dftm_top #(
    parameter int unsigned BRAKE_CYC = dftm_pkg::BRAKE_LOW_CYC,
    parameter int unsigned KPAD_CYC = dftm_pkg::KEYPAD_LOSS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic faultReset,
    input wire dftm_pkg::dftm_det_t det,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic tripActive,
    output logic [4:0] faultCode,
    output logic irq
);
    localparam int N = dftm_pkg::NUM_FAULTS;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    localparam int DW = $bits(dftm_pkg::dftm_det_t);
    logic [DW-1:0] detMeta_reg, detSync_reg;
    logic resMeta_reg, resSync_reg, resPrev_reg;
    dftm_pkg::dftm_det_t ds;
    assign ds = dftm_pkg::dftm_det_t'(detSync_reg);

    // Two stages; only the second stage is read by logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            detMeta_reg <= '0;
            detSync_reg <= '0;
            resMeta_reg <= 1'b0;
            resSync_reg <= 1'b0;
            resPrev_reg <= 1'b0;
        end else begin
            detMeta_reg <= det;
            detSync_reg <= detMeta_reg;
            resMeta_reg <= faultReset;
            resSync_reg <= resMeta_reg;
            resPrev_reg <= resSync_reg;
        end
    end
    logic resetPulse;
    assign resetPulse = resSync_reg & ~resPrev_reg;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [31:0] config_reg;
    logic [15:0] speed_reg, speedRef_reg, overspeed_reg, devLimit_reg;
    logic [15:0] current_reg, brakeRel_reg, noLoad_reg;
    logic [N-1:0] istat_reg, imask_reg, hist_reg, trip_reg;
    logic [2:0] slotSeen_reg;
    logic [1:0] settle_reg;
    logic [N-1:0] cond;
    logic [N-1:0] istatSet;

    // Brake and keypad timers: counters that hold at their limit
    logic [31:0] brakeCnt_reg, kpadCnt_reg;
    logic ctrlVector, brakeLow;
    assign ctrlVector = config_reg[dftm_pkg::C_CTRL_LO +: 2] == dftm_pkg::CTRL_VECTOR;
    assign brakeLow = ds.brakeOutAssigned && ds.running && !ctrlVector
        && current_reg < brakeRel_reg;

    // Brake-low accumulator, restarted whenever current recovers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            brakeCnt_reg <= '0;
        end else if (!brakeLow) begin
            brakeCnt_reg <= '0;
        end else if (brakeCnt_reg < BRAKE_CYC) begin
            brakeCnt_reg <= brakeCnt_reg + 32'h00000001;
        end
    end

    // Keypad silence counter, only meaningful while keypad drives the run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            kpadCnt_reg <= '0;
        end else if (ds.keypadAlive || !ds.keypadRun) begin
            kpadCnt_reg <= '0;
        end else if (kpadCnt_reg < KPAD_CYC) begin
            kpadCnt_reg <= kpadCnt_reg + 32'h00000001;
        end
    end

    // Slot presence captured on the third edge, once the synchronisers hold real levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slotSeen_reg <= '0;
            settle_reg <= '0;
        end else if (settle_reg != 2'h3) begin
            slotSeen_reg <= ds.optPresent;
            settle_reg <= settle_reg + 2'h1;
        end
    end

    logic [15:0] speedDiff;
    assign speedDiff = speed_reg > speedRef_reg ? speed_reg - speedRef_reg
        : speedRef_reg - speed_reg;

    // Fault conditions from detectors and settings
    always_comb begin
        cond = '0;
        cond[dftm_pkg::F_NTC] = ds.ntcFault;
        cond[dftm_pkg::F_FAN] = ds.fanError && !config_reg[dftm_pkg::C_FANACT]
            && config_reg[dftm_pkg::C_SMALL];
        cond[dftm_pkg::F_THERM] = ds.extThermHigh && config_reg[dftm_pkg::C_THERM];
        cond[dftm_pkg::F_PWRITE] = ds.paramWriteFail;
        cond[dftm_pkg::F_OVSPD] = speed_reg > overspeed_reg;
        cond[dftm_pkg::F_DEVSPD] = config_reg[dftm_pkg::C_DEVCHK]
            && speedDiff > devLimit_reg;
        cond[dftm_pkg::F_ENC] = config_reg[dftm_pkg::C_ENCCHK] && ds.encoderFault;
        cond[dftm_pkg::F_PREPID] = ds.prePidActive && ds.prePidLow;
        cond[dftm_pkg::F_BRAKE] = brakeCnt_reg >= BRAKE_CYC
            || (ds.brakeOutAssigned && ds.running && ctrlVector
            && current_reg < {1'b0, noLoad_reg[15:1]});
        cond[dftm_pkg::F_KPAD] = config_reg[dftm_pkg::C_KPLOSS]
            && kpadCnt_reg >= KPAD_CYC;
        cond[dftm_pkg::F_CMD] = config_reg[dftm_pkg::C_CMDLOSS]
            && ds.cmdFail && ds.running && !ds.keypadRun;
        cond[dftm_pkg::F_IOB] = ds.ioBoardFault;
        cond[dftm_pkg::F_FATAL0] = ds.fatalDiag[0];
        cond[dftm_pkg::F_FATAL1] = ds.fatalDiag[1];
    end

    // ---------------------------------------------------------------
    // Trip state per fault, by clearing discipline
    // ---------------------------------------------------------------
    logic [2:0] slotLost;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_slot
            assign slotLost[gi] = (settle_reg == 2'h3) && slotSeen_reg[gi]
                && !ds.optPresent[gi];
        end
        for (gi = 0; gi < N; gi++) begin : g_trip
            logic c;
            if (gi >= dftm_pkg::F_OPT1 && gi <= dftm_pkg::F_OPT3) begin : g_opt
                assign c = slotLost[gi - dftm_pkg::F_OPT1];
            end else begin : g_std
                assign c = cond[gi];
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    trip_reg[gi] <= 1'b0;
                end else if (dftm_pkg::LEVEL_MASK[gi]) begin
                    trip_reg[gi] <= c;
                end else if (c) begin
                    trip_reg[gi] <= 1'b1;
                end else if (resetPulse && !dftm_pkg::FATAL_MASK[gi]) begin
                    trip_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // History records latch and fatal faults only; cleared by power-on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hist_reg <= '0;
        end else begin
            hist_reg <= hist_reg | (trip_reg & ~dftm_pkg::LEVEL_MASK);
        end
    end

    // Lowest-numbered active fault chooses the displayed code
    function automatic logic [4:0] firstSet(input logic [N-1:0] v);
        firstSet = 5'h1F;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                firstSet = 5'(i);
            end
        end
    endfunction

    // Combined trip blocks the power stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tripActive <= 1'b0;
            faultCode <= 5'h1F;
        end else begin
            tripActive <= |trip_reg;
            faultCode <= firstSet(trip_reg);
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status: rising trips set, write-one clears, set wins
    // ---------------------------------------------------------------
    logic [N-1:0] tripPrev_reg;
    logic wrFire;
    logic [7:0] wrAddr_reg;
    logic [31:0] wrData_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tripPrev_reg <= '0;
            istat_reg <= '0;
            irq <= 1'b0;
        end else begin
            tripPrev_reg <= trip_reg;
            istat_reg <= (istat_reg & ~((wrFire && wrAddr_reg == dftm_pkg::A_ISTAT)
                ? wrData_reg[N-1:0] : '0)) | istatSet;
            irq <= |(istat_reg & imask_reg);
        end
    end
    assign istatSet = trip_reg & ~tripPrev_reg;

    // ---------------------------------------------------------------
    // AXI4-Lite slave: write
    // ---------------------------------------------------------------
    logic awHave_reg, wHave_reg;
    assign wrFire = awHave_reg && wHave_reg && !bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            wrAddr_reg <= '0;
            wrData_reg <= '0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                awHave_reg <= 1'b1;
                wrAddr_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wHave_reg <= 1'b1;
                wrData_reg <= wdata;
                wready <= 1'b0;
            end
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp <= (wrAddr_reg <= dftm_pkg::A_HIST) ? 2'h0 : 2'h2;
                awHave_reg <= 1'b0;
                wHave_reg <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    logic wstrbOk;
    assign wstrbOk = 1'b1;
    // Writable settings; strobes ignored beyond full word for simplicity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_reg <= dftm_pkg::CONFIG_RST;
            speed_reg <= '0;
            speedRef_reg <= '0;
            overspeed_reg <= dftm_pkg::OVSPD_RST;
            devLimit_reg <= dftm_pkg::OVSPD_RST;
            current_reg <= '0;
            brakeRel_reg <= '0;
            noLoad_reg <= '0;
            imask_reg <= '0;
        end else if (wrFire && wstrbOk) begin
            case (wrAddr_reg)
                dftm_pkg::A_CONFIG: config_reg <= wrData_reg;
                dftm_pkg::A_SPEED: {speedRef_reg, speed_reg} <= wrData_reg;
                dftm_pkg::A_CURRENT: {brakeRel_reg, current_reg} <= wrData_reg;
                dftm_pkg::A_TRIP: {devLimit_reg, overspeed_reg} <= wrData_reg;
                dftm_pkg::A_IMASK: imask_reg <= wrData_reg[N-1:0];
                dftm_pkg::A_CODE: noLoad_reg <= wrData_reg[15:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite slave: read, one cycle after address
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= 2'h0;
            case (araddr)
                dftm_pkg::A_CONFIG: rdata <= config_reg;
                dftm_pkg::A_SPEED: rdata <= {speedRef_reg, speed_reg};
                dftm_pkg::A_CURRENT: rdata <= {brakeRel_reg, current_reg};
                dftm_pkg::A_TRIP: rdata <= {15'h0000, trip_reg};
                dftm_pkg::A_ISTAT: rdata <= {15'h0000, istat_reg};
                dftm_pkg::A_IMASK: rdata <= {15'h0000, imask_reg};
                dftm_pkg::A_CODE: rdata <= {16'h0000, noLoad_reg};
                dftm_pkg::A_HIST: rdata <= {15'h0000, hist_reg};
                default: begin
                    rdata <= '0;
                    rresp <= 2'h2;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    fatal_hold_a: assert property (@(posedge clk) disable iff (rst)
        trip_reg[dftm_pkg::F_FATAL0] |=> trip_reg[dftm_pkg::F_FATAL0])
        else $error("fatal trip cleared without power cycle");
    level_drop_a: assert property (@(posedge clk) disable iff (rst)
        !cond[dftm_pkg::F_CMD] |=> !trip_reg[dftm_pkg::F_CMD])
        else $error("level trip held after condition cleared");
    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        trip_reg[dftm_pkg::F_NTC] && !resetPulse |=> trip_reg[dftm_pkg::F_NTC])
        else $error("latch trip released without reset");
    ntc_raise_a: assert property (@(posedge clk) disable iff (rst)
        ds.ntcFault |=> trip_reg[dftm_pkg::F_NTC])
        else $error("sensor fault did not trip");
    trip_merge_a: assert property (@(posedge clk) disable iff (rst)
        (|trip_reg) |=> tripActive)
        else $error("trip output missing");
    ovspd_raise_a: assert property (@(posedge clk) disable iff (rst)
        speed_reg > overspeed_reg |=> trip_reg[dftm_pkg::F_OVSPD])
        else $error("overspeed not tripped");
    kpad_time_a: assert property (@(posedge clk) disable iff (rst)
        trip_reg[dftm_pkg::F_KPAD] |-> $past(config_reg[dftm_pkg::C_KPLOSS]))
        else $error("keypad trip while disabled");
    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        (|(istat_reg & imask_reg)) |=> irq)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

// ---- dv/dftm_detector_model.sv ----
// Far-side model: fault detectors, keypad link and option slots as detector levels.
// Assumes the bench sets faultOn after a clock edge; one bit per fault index.
`timescale 1ns/1ns
`default_nettype none
module dftm_detector_model (
    input wire logic [16:0] faultOn,
    output var dftm_pkg::dftm_det_t det
);
    // -------------------------------------------------------------------
    // Detector levels
    // -------------------------------------------------------------------
    // Run context held active so that loss faults depend only on the settings
    always_comb begin
        det.ntcFault = faultOn[0];
        det.fanError = faultOn[1];
        det.extThermHigh = faultOn[2];
        det.paramWriteFail = faultOn[3];
        det.encoderFault = faultOn[6];
        det.prePidActive = 1'b1;
        det.prePidLow = faultOn[7];
        det.brakeOutAssigned = 1'b1;
        det.keypadRun = ~faultOn[10]; // Command loss is injected with a non-keypad source
        det.keypadAlive = ~faultOn[9]; // Link silent while the loss is injected
        det.cmdFail = faultOn[10];
        det.running = 1'b1;
        det.optPresent = ~faultOn[13:11]; // All slots populated at power-up
        det.ioBoardFault = faultOn[14];
        det.fatalDiag = faultOn[16:15];
    end
endmodule
`default_nettype wire

// ---- dv/drive_fault_trip_manager_tb.sv ----
// Self-checking bench for the drive fault-trip manager.
// Assumes dftm_detector_model and shortened brake and keypad timers.
`timescale 1ns/1ns
`default_nettype none
module drive_fault_trip_manager_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic faultReset = 1'b0;
    logic [16:0] faultOn = 17'h00000;
    dftm_pkg::dftm_det_t det;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid, tripActive, irq;
    logic [1:0] bresp, rresp, lastB;
    logic [31:0] rdata;
    logic [4:0] faultCode;
    logic [33:0] expQ[$];
    int fails = 0;
    int n_tests = 0;
    int seed = 50;

    dftm_top #(.BRAKE_CYC(20), .KPAD_CYC(10)) DUT (.clk(clk), .rst(rst), .faultReset(faultReset),
        .det(det), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .tripActive(tripActive),
        .faultCode(faultCode), .irq(irq));
    dftm_detector_model farSide (.faultOn(faultOn), .det(det));

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // -------------------------------------------------------------------
    // Bus tasks and comparison
    // -------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [33:0] bitOf(input int f);
        return 34'h000000001 << f;
    endfunction
    // Address and data offered together; each released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clk);
        lastB = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    // Expected word noted before the request; the monitor takes it off
    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        expQ.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdTrip(input logic [33:0] exp);
        rd(dftm_pkg::A_TRIP, exp);
    endtask
    task automatic userReset();
        faultReset <= 1'b1;
        cyc(4);
        faultReset <= 1'b0;
        cyc(4);
    endtask
    // Read monitor: response code and data compared as one word
    always @(posedge clk) begin
        if (rvalid && rready) begin
            chk("read word", expQ.pop_front(), {rresp, rdata});
        end
    end

    // -------------------------------------------------------------------
    // Scenario tasks
    // -------------------------------------------------------------------
    task automatic latchCase(input int f, input logic [31:0] cfg, input bit en);
        logic [33:0] e;
        e = en ? bitOf(f) : 34'h000000000;
        wr(dftm_pkg::A_CONFIG, cfg);
        faultOn[f] <= 1'b1;
        cyc(8);
        rdTrip(e);
        chk("tripActive", {33'h0, en}, {33'h0, tripActive});
        chk("faultCode", en ? 34'(f) : 34'h00000001F, {29'h0, faultCode});
        faultOn[f] <= 1'b0;
        cyc(8);
        rdTrip(e);
        userReset();
        rdTrip(34'h000000000);
    endtask
    task automatic levelCase(input int f, input logic [31:0] cfg, input bit en);
        wr(dftm_pkg::A_CONFIG, cfg);
        faultOn[f] <= 1'b1;
        cyc(20);
        rdTrip(en ? bitOf(f) : 34'h000000000);
        faultOn[f] <= 1'b0;
        cyc(8);
        rdTrip(34'h000000000);
    endtask

    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        cyc(30000);
        fails++;
        conclude();
    end

    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(1);
        rd(dftm_pkg::A_CONFIG, {2'h0, dftm_pkg::CONFIG_RST});
        rd(8'h20, 34'h200000000);
        wr(8'h20, 32'h00000000);
        chk("bresp", 34'h000000002, {32'h0, lastB});
        $display("test reset and map done");
        latchCase(dftm_pkg::F_NTC, 32'h00000001, 1'b1);
        latchCase(dftm_pkg::F_FAN, 32'h00000001, 1'b0);
        latchCase(dftm_pkg::F_FAN, 32'h00000040, 1'b1);
        latchCase(dftm_pkg::F_THERM, 32'h00000001, 1'b0);
        latchCase(dftm_pkg::F_THERM, 32'h00000003, 1'b1);
        latchCase(dftm_pkg::F_PWRITE, 32'h00000001, 1'b1);
        latchCase(dftm_pkg::F_ENC, 32'h00000001, 1'b0);
        latchCase(dftm_pkg::F_ENC, 32'h00000009, 1'b1);
        latchCase(dftm_pkg::F_PREPID, 32'h00000001, 1'b1);
        for (int i = 0; i < 3; i++) latchCase(dftm_pkg::F_OPT1 + i, 32'h00000001, 1'b1);
        latchCase(dftm_pkg::F_IOB, 32'h00000001, 1'b1);
        levelCase(dftm_pkg::F_KPAD, 32'h00000001, 1'b0);
        levelCase(dftm_pkg::F_KPAD, 32'h00000011, 1'b1);
        levelCase(dftm_pkg::F_CMD, 32'h00000001, 1'b0);
        levelCase(dftm_pkg::F_CMD, 32'h00000021, 1'b1);
        $display("test detector trips done");
        // Random speeds at or below the level must not trip
        wr(dftm_pkg::A_TRIP, 32'hFFFF0064);
        repeat (4) begin
            wr(dftm_pkg::A_SPEED, $unsigned($random(seed)) % 101);
            cyc(8);
            rdTrip(34'h000000000);
        end
        wr(dftm_pkg::A_SPEED, 32'h00000065);
        cyc(8);
        rdTrip(bitOf(dftm_pkg::F_OVSPD));
        wr(dftm_pkg::A_CONFIG, 32'h00000005);
        wr(dftm_pkg::A_TRIP, 32'h0010FFFF);
        wr(dftm_pkg::A_SPEED, 32'h01000110);
        userReset();
        rdTrip(34'h000000000);
        wr(dftm_pkg::A_SPEED, 32'h01000111);
        cyc(8);
        rdTrip(bitOf(dftm_pkg::F_DEVSPD));
        wr(dftm_pkg::A_SPEED, 32'h00000000);
        wr(dftm_pkg::A_CONFIG, 32'h00000001);
        wr(dftm_pkg::A_CURRENT, 32'h00500010);
        userReset();
        rdTrip(34'h000000000);
        cyc(20);
        rdTrip(bitOf(dftm_pkg::F_BRAKE));
        wr(dftm_pkg::A_CODE, 32'h00000040);
        wr(dftm_pkg::A_CONFIG, 32'h00000301);
        wr(dftm_pkg::A_CURRENT, 32'h00000020);
        userReset();
        cyc(30);
        rdTrip(34'h000000000);
        wr(dftm_pkg::A_CURRENT, 32'h0000001F);
        cyc(30);
        rdTrip(bitOf(dftm_pkg::F_BRAKE));
        wr(dftm_pkg::A_CONFIG, 32'h00000001);
        wr(dftm_pkg::A_CURRENT, 32'h00000000);
        $display("test speed and brake done");
        // Fatal faults survive the user reset, only power-on reset clears them
        faultOn[16:15] <= 2'h3;
        cyc(8);
        rdTrip(34'h000018100);
        faultOn[16:15] <= 2'h0;
        userReset();
        rdTrip(34'h000018000);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        rdTrip(34'h000000000);
        levelCase(dftm_pkg::F_CMD, 32'h00000021, 1'b1);
        rd(dftm_pkg::A_HIST, 34'h000000000);
        faultOn[dftm_pkg::F_NTC] <= 1'b1;
        cyc(8);
        rd(dftm_pkg::A_ISTAT, bitOf(dftm_pkg::F_NTC) | bitOf(dftm_pkg::F_CMD));
        chk("irq masked", 34'h0, {33'h0, irq});
        wr(dftm_pkg::A_IMASK, 32'h00000001);
        cyc(3);
        chk("irq", 34'h1, {33'h0, irq});
        faultOn[dftm_pkg::F_NTC] <= 1'b0;
        userReset();
        wr(dftm_pkg::A_ISTAT, 32'h00000401);
        cyc(3);
        chk("irq cleared", 34'h0, {33'h0, irq});
        rd(dftm_pkg::A_ISTAT, 34'h000000000);
        $display("test fatal and interrupt done");
        conclude();
    end
endmodule
`default_nettype wire
